// file: core/asp_uart.sv
// Asynchronous serial port with transmit and receive FIFOs.
// Assumes all inputs synchronous to core_clk; configuration held steady.
`timescale 1ns/1ns
`default_nettype none
`include "asp_consts.svh"
// Function
// - Separate transmit and receive FIFOs, sixteen bytes each.
// - FIFO can shrink to one byte for double-buffered operation.
// - Trigger levels at 1/8, 1/4, 1/2, 3/4 and 7/8 of depth.
// - Five to eight data bits per character, both directions.
// - Even, odd, stick or no parity, generated and checked.
// - One or two stop bits sent per character.
// - Transmit break on demand; detect break on the receive line.
// - RTS/CTS flow control pauses the sender when receiver is full.
// - Interrupts on FIFO level crossings and end of transmission.
// - Separate DMA request lines for transmit and receive.
// - Receive single request when data present, burst at level.
// - Transmit single request when space free, burst at level.
// - Bit clock from system clock by divider, up to 3 Mbps.
module asp_uart #(
	parameter int DEPTH = `ASP_FIFO_DEPTH,
	parameter int DIV_W = `ASP_DIV_W
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] baud_div,
	input wire asp_pkg::asp_len_t data_len,
	input wire logic parity_en,
	input wire logic parity_even,
	input wire logic parity_stick,
	input wire logic two_stop,
	input wire logic send_break,
	input wire logic fifo_en,
	input wire logic flow_en,
	input wire asp_pkg::asp_lvl_t tx_lvl,
	input wire asp_pkg::asp_lvl_t rx_lvl,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic rxd,
	input wire logic cts_n,
	output logic txd,
	output logic rts_n,
	output logic tx_full,
	output logic rx_avail,
	output logic [7:0] rx_data,
	output logic parity_err,
	output logic frame_err,
	output logic break_det,
	output logic overrun,
	output logic irq_rx_level,
	output logic irq_tx_level,
	output logic irq_eot,
	output logic dma_rx_single,
	output logic dma_rx_burst,
	output logic dma_tx_single,
	output logic dma_tx_burst
);
	import asp_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	if (DEPTH < 8 || DEPTH % 8 != 0 || (1 << AW) != DEPTH || DIV_W < 3)
		$error("asp_uart: DEPTH must be a power of two >= 8, DIV_W >= 3");
	typedef struct packed {
		logic [DIV_W-1:0] bdiv;
		logic [DEPTH-1:0][7:0] txm;
		logic [AW-1:0] twp, trp;
		logic [CW-1:0] txc;
		asp_tx_st_t tst;
		logic [3:0] ttk, tbi;
		logic [7:0] tsh;
		logic tpar, tsb, tbit;
		logic [DEPTH-1:0][7:0] rxm;
		logic [AW-1:0] rwp, rrp;
		logic [CW-1:0] rxc;
		asp_rx_st_t rst;
		logic [3:0] rtk, rbi;
		logic [7:0] rsh;
		logic rpar, rperr, rpb, rbrk;
		logic txd, rts_n, tx_full, rx_avail;
		logic [7:0] rdata;
		logic perr, ferr, brk, ovr;
		logic irq_rx, irq_tx, irq_eot;
		logic drs, drb, dts, dtb;
	} asp_state_t;
	asp_state_t s, n;
	logic [1:0] rst_sync;
	logic rst_q;
	// Level that trips burst requests and level interrupts: fill count for receive, free space for transmit
	function automatic logic [CW-1:0] lvl_count(asp_lvl_t l, logic fe);
		logic [CW-1:0] d;
		d = CW'(DEPTH);
		if (!fe)
			return CW'(1);
		case (l)
			ASP_LVL_1_8: return d >> 3;
			ASP_LVL_1_4: return d >> 2;
			ASP_LVL_1_2: return d >> 1;
			ASP_LVL_3_4: return (d >> 1) + (d >> 2);
			default: return d - (d >> 3);
		endcase
	endfunction
	// Parity bit for a given running XOR of the data
	function automatic logic par_bit(logic x, logic ev, logic st);
		return st ? !ev : (ev ? x : !x);
	endfunction
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_q = rst_sync[1];
	logic tk, tend, rsmp, tpush, tpop, rpush, rpop;
	logic [3:0] nb;
	logic [CW-1:0] dep, thr_t, thr_r;
	logic [7:0] mask, rword;
	always_comb begin
		n = s;
		nb = `ASP_MIN_BITS + {2'h0, data_len};
		mask = 8'hff >> (4'h8 - nb);
		dep = fifo_en ? CW'(DEPTH) : CW'(1);
		thr_t = lvl_count(tx_lvl, fifo_en);
		thr_r = lvl_count(rx_lvl, fifo_en);
		tk = (s.bdiv == '0);
		n.bdiv = tk ? baud_div : s.bdiv - 1'b1;
		tend = tk && s.ttk == `ASP_LAST_TICK;
		rsmp = tk && s.rtk == `ASP_LAST_TICK;
		tpop = 1'b0;
		rpush = 1'b0;
		rword = s.rsh >> (4'h8 - nb);
		n.perr = 1'b0;
		n.ferr = 1'b0;
		n.brk = 1'b0;
		n.ovr = 1'b0;
		tpush = wr_en && s.txc < dep;
		if (tpush) begin
			n.txm[s.twp] = wr_data;
			n.twp = fifo_en ? s.twp + 1'b1 : '0;
		end
		if (tk)
			n.ttk = s.ttk + 1'b1;
		case (s.tst)
			T_IDLE: begin
				n.ttk = 4'h0;
				if (tk && s.txc != '0 && (!flow_en || !cts_n)) begin
					tpop = 1'b1;
					n.tsh = s.txm[s.trp];
					n.tpar = ^(s.txm[s.trp] & mask);
					n.trp = fifo_en ? s.trp + 1'b1 : '0;
					n.tst = T_START;
					n.tbit = 1'b0;
				end
			end
			T_START: if (tend) begin
				n.tst = T_DATA;
				n.tbi = 4'h0;
				n.tbit = s.tsh[0];
			end
			T_DATA: if (tend) begin
				if (s.tbi == nb - 1'b1) begin
					n.tsb = 1'b0;
					n.tst = parity_en ? T_PAR : T_STOP;
					n.tbit = parity_en ?
						par_bit(s.tpar, parity_even, parity_stick) : 1'b1;
				end else begin
					n.tbi = s.tbi + 1'b1;
					n.tsh = s.tsh >> 1;
					n.tbit = s.tsh[1];
				end
			end
			T_PAR: if (tend) begin
				n.tst = T_STOP;
				n.tbit = 1'b1;
			end
			T_STOP: if (tend) begin
				if (two_stop && !s.tsb)
					n.tsb = 1'b1;
				else
					n.tst = T_IDLE;
			end
			default: n.tst = T_IDLE;
		endcase
		n.txc = s.txc + CW'(tpush) - CW'(tpop);
		rpop = rd_en && s.rxc != '0;
		if (rpop)
			n.rrp = fifo_en ? s.rrp + 1'b1 : '0;
		if (tk)
			n.rtk = s.rtk + 1'b1;
		case (s.rst)
			R_IDLE: begin
				n.rtk = 4'h0;
				if (s.rbrk)
					n.rbrk = !rxd;
				else if (tk && !rxd) begin
					n.rst = R_START;
					n.rperr = 1'b0;
					n.rpb = 1'b0;
				end
			end
			R_START: if (tk && s.rtk == `ASP_MID_TICK) begin
				n.rtk = 4'h0;
				n.rst = rxd ? R_IDLE : R_DATA;
				n.rbi = 4'h0;
				n.rpar = 1'b0;
			end
			R_DATA: if (rsmp) begin
				n.rsh = {rxd, s.rsh[7:1]};
				n.rpar = s.rpar ^ rxd;
				n.rbi = s.rbi + 1'b1;
				if (s.rbi == nb - 1'b1)
					n.rst = parity_en ? R_PAR : R_STOP;
			end
			R_PAR: if (rsmp) begin
				n.rpb = rxd;
				n.rperr = rxd != par_bit(s.rpar, parity_even, parity_stick);
				n.rst = R_STOP;
			end
			R_STOP: if (rsmp) begin
				n.rst = R_IDLE;
				if (rword == 8'h00 && !s.rpb && !rxd) begin
					n.brk = 1'b1;
					n.rbrk = 1'b1;
				end else begin
					n.ferr = !rxd;
					n.perr = s.rperr;
					rpush = s.rxc < dep || rpop;
					n.ovr = !rpush;
				end
			end
			default: n.rst = R_IDLE;
		endcase
		if (rpush) begin
			n.rxm[s.rwp] = rword;
			n.rwp = fifo_en ? s.rwp + 1'b1 : '0;
		end
		n.rxc = s.rxc + CW'(rpush) - CW'(rpop);

		n.txd = !send_break && n.tbit;
		n.rts_n = flow_en && n.rxc >= dep;
		n.tx_full = n.txc >= dep;
		n.rx_avail = n.rxc != '0;
		n.rdata = n.rxm[n.rrp];
		n.irq_rx = n.rxc >= thr_r;
		n.irq_tx = dep - n.txc >= thr_t;
		n.irq_eot = n.txc == '0 && n.tst == T_IDLE;
		n.drs = n.rxc != '0;
		n.drb = n.rxc >= thr_r;
		n.dts = n.txc < dep;
		n.dtb = dep - n.txc >= thr_t;
	end

	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			s <= '0;
			s.tst <= T_IDLE;
			s.rst <= R_IDLE;
			s.tbit <= 1'b1;
			s.txd <= 1'b1;
			s.irq_tx <= 1'b1;
			s.irq_eot <= 1'b1;
			s.dts <= 1'b1;
			s.dtb <= 1'b1;
		end else
			s <= n;
	end

	assign txd = s.txd;
	assign rts_n = s.rts_n;
	assign tx_full = s.tx_full;
	assign rx_avail = s.rx_avail;
	assign rx_data = s.rdata;
	assign parity_err = s.perr;
	assign frame_err = s.ferr;
	assign break_det = s.brk;
	assign overrun = s.ovr;
	assign irq_rx_level = s.irq_rx;
	assign irq_tx_level = s.irq_tx;
	assign irq_eot = s.irq_eot;
	assign dma_rx_single = s.drs;
	assign dma_rx_burst = s.drb;
	assign dma_tx_single = s.dts;
	assign dma_tx_burst = s.dtb;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_q);

	sequence s_tx_launch;
		s.tst == T_IDLE ##1 s.tst == T_START;
	endsequence
	property p_start_low;
		s_tx_launch |-> !txd || send_break;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start not low");
	property p_cap;
		s.txc <= CW'(DEPTH) && s.rxc <= CW'(DEPTH);
	endproperty
	a_cap: assert property (p_cap) else $error("fifo count overflow");
	property p_onebyte;
		!fifo_en && !$past(fifo_en) |-> s.txc <= 1 && s.rxc <= 1;
	endproperty
	a_onebyte: assert property (p_onebyte) else $error("depth not one");
	property p_bits;
		s.tst == T_DATA |-> s.tbi < nb;
	endproperty
	a_bits: assert property (p_bits) else $error("data bit overrun");
	property p_stop_high;
		s.tst == T_STOP && !send_break |-> txd;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop low");
	property p_break;
		send_break |=> !txd;
	endproperty
	a_break: assert property (p_break) else $error("break not driven");
	property p_cts;
		flow_en && cts_n && s.tst == T_IDLE |=> s.tst == T_IDLE;
	endproperty
	a_cts: assert property (p_cts) else $error("sent while paused");
	property p_eot;
		irq_eot && !$past(send_break) |-> txd && s.txc == '0;
	endproperty
	a_eot: assert property (p_eot) else $error("early end of tx");
	property p_rx_single;
		(dma_rx_burst |-> dma_rx_single) and (rpush |=> dma_rx_single);
	endproperty
	a_rx_single: assert property (p_rx_single) else $error("rx dma bad");
	property p_tx_single;
		(tx_full |-> !dma_tx_single) and (tpop |=> dma_tx_single);
	endproperty
	a_tx_single: assert property (p_tx_single) else $error("tx dma bad");
	property p_tick;
		s.bdiv != '0 |=> s.bdiv == $past(s.bdiv) - 1'b1;
	endproperty
	a_tick: assert property (p_tick) else $error("divider stalled");
endmodule
`default_nettype wire

// file: core/asp_consts.svh
// Constants for the asynchronous serial port: depths, framing, timing.
// Assumes it is included by bare name from the core sources.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_FIFO_DEPTH 16
`define ASP_WORD_W 8
`define ASP_DIV_W 16
`define ASP_OVS 16
`define ASP_MID_TICK 4'h7
`define ASP_LAST_TICK 4'hf
`define ASP_MIN_BITS 4'h5
`define ASP_CLK_HZ 250000000
`define ASP_MAX_BPS 3000000
`define ASP_MIN_DIV ((`ASP_CLK_HZ / (`ASP_OVS * `ASP_MAX_BPS)) - 1)
`define ASP_LVL_1_8 3'h0
`define ASP_LVL_1_4 3'h1
`define ASP_LVL_1_2 3'h2
`define ASP_LVL_3_4 3'h3
`define ASP_LVL_7_8 3'h4
`define ASP_TX_RST 5'h01
`define ASP_RX_RST 5'h01
`endif

// file: core/asp_pkg.sv
// Types for the asynchronous serial port.
// Assumes asp_consts.svh is on the include path.
`include "asp_consts.svh"
package asp_pkg;
	typedef enum logic [2:0] {
		ASP_LVL_1_8 = `ASP_LVL_1_8,
		ASP_LVL_1_4 = `ASP_LVL_1_4,
		ASP_LVL_1_2 = `ASP_LVL_1_2,
		ASP_LVL_3_4 = `ASP_LVL_3_4,
		ASP_LVL_7_8 = `ASP_LVL_7_8
	} asp_lvl_t;
	typedef enum logic [1:0] {
		ASP_LEN5 = 2'h0, ASP_LEN6 = 2'h1, ASP_LEN7 = 2'h2, ASP_LEN8 = 2'h3
	} asp_len_t;
	typedef enum logic [4:0] {
		T_IDLE = 5'h01, T_START = 5'h02, T_DATA = 5'h04,
		T_PAR = 5'h08, T_STOP = 5'h10
	} asp_tx_st_t;
	typedef enum logic [4:0] {
		R_IDLE = 5'h01, R_START = 5'h02, R_DATA = 5'h04,
		R_PAR = 5'h08, R_STOP = 5'h10
	} asp_rx_st_t;
endpackage

// file: sim/asp_remote.sv
// Remote serial device: decodes frames on txd, drives frames on rxd.
// Assumes div equals the port's divider: a bit lasts 16*(div+1) clocks.
`timescale 1ns/1ns
`default_nettype none
module asp_remote (
	input wire logic core_clk,
	input wire logic txd,
	input wire logic rts_n,
	input wire logic [15:0] div,
	input wire logic [3:0] nbits,
	output logic rxd
);
	logic [12:0] got[$];
	logic [12:0] sh;
	initial rxd = 1'b1;
	// Start edge, then one sample in the middle of every bit
	always begin
		@(negedge txd);
		sh = '1;
		repeat (8 * (div + 1)) @(posedge core_clk);
		for (int i = 0; i < nbits; i++) begin
			if (i > 0)
				repeat (16 * (div + 1)) @(posedge core_clk);
			sh[i] = txd;
		end
		got.push_back(sh);
	end
	task automatic send(input logic [12:0] f, input int n);
		// Hold off while the port says its receive FIFO is full
		while (rts_n)
			@(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (16 * (div + 1)) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: sim/asp_uart_bench.sv
// Bench for the serial port: random framing, FIFO levels, break.
// Assumes the remote model on the line; divider zero but for one test.
`timescale 1ns/1ns
`default_nettype none
module asp_uart_bench;
	import asp_pkg::*;
	logic core_clk, rst_n, pe, ev, st, ts, sb, fe, fl, wr_en, rd_en;
	logic cts_n, rxd, txd, rts_n, tx_full, rx_avail, irq_rx, irq_tx, eot;
	logic drs, drb, dts, dtb, perr, brk, ovr, fer, clr;
	logic [3:0] seen;
	logic [15:0] bd;
	logic [7:0] wd, rx_data, d;
	logic [3:0] nb;
	logic [12:0] f;
	asp_len_t len;
	asp_lvl_t tl, rl;
	int err_total, checked, cyc_n, n;
	asp_uart asp_uart_i (.core_clk(core_clk), .rst_n(rst_n),
		.baud_div(bd), .data_len(len), .parity_en(pe),
		.parity_even(ev), .parity_stick(st), .two_stop(ts),
		.send_break(sb), .fifo_en(fe), .flow_en(fl), .tx_lvl(tl),
		.rx_lvl(rl), .wr_data(wd), .wr_en(wr_en), .rd_en(rd_en),
		.rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
		.tx_full(tx_full), .rx_avail(rx_avail), .rx_data(rx_data),
		.parity_err(perr), .frame_err(fer), .break_det(brk),
		.overrun(ovr), .irq_rx_level(irq_rx), .irq_tx_level(irq_tx),
		.irq_eot(eot), .dma_rx_single(drs), .dma_rx_burst(drb),
		.dma_tx_single(dts), .dma_tx_burst(dtb));
	asp_remote remote_i (.core_clk(core_clk), .txd(txd), .rts_n(rts_n),
		.div(bd), .nbits(nb), .rxd(rxd));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		seen <= clr ? 4'h0 : seen | {fer, perr, brk, ovr};
		cyc_n++;
		if (cyc_n == 40000) begin
			err_total++;
			results();
		end
	end
	function automatic int th(input int k);
		return k == 4 ? 14 : k == 3 ? 12 : 2 << k;
	endfunction
	function automatic logic [12:0] frm(input logic [7:0] v);
		logic [12:0] r;
		int k;
		k = 5 + len;
		r = '1;
		r[0] = 1'b0;
		for (int i = 0; i < k; i++)
			r[i + 1] = v[i];
		if (pe)
			r[k + 1] = st ? !ev : ~(ev ^ (^(v & (8'hff >> (8 - k)))));
		return r;
	endfunction
	task chk(input logic [12:0] g, e, input string m);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task cy(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task wr(input logic [7:0] v);
		wd <= v;
		wr_en <= 1'b1;
		cy(1);
		wr_en <= 1'b0;
	endtask
	task pop;
		rd_en <= 1'b1;
		cy(1);
		rd_en <= 1'b0;
	endtask
	// Clearing through a flag keeps the sticky flags to one driver
	task clr_seen;
		clr <= 1'b1;
		cy(1);
		clr <= 1'b0;
	endtask
	task frame_wait;
		for (int i = 0; i < 1000 && remote_i.got.size() == 0; i++)
			cy(1);
	endtask
	task results;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		void'($urandom(53));
		{rst_n, pe, ev, st, ts, sb, fl, wr_en, rd_en, cts_n} = '0;
		{fe, wd, nb, seen, clr} = {1'b1, 8'h00, 4'hb, 4'h0, 1'b0};
		bd = 16'h0000;
		len = ASP_LEN8;
		tl = ASP_LVL_1_8;
		rl = ASP_LVL_1_8;
		cy(16);
		rst_n <= 1'b1;
		cy(4);
		chk({txd, eot, dts, tx_full, rx_avail}, 5'h1c, "reset");
		$display("test reset done");
		for (int t = 0; t < 32; t++) begin
			len <= asp_len_t'(t[1:0]);
			{st, ev, pe} <= t[4:2];
			ts <= 1'($urandom);
			d = 8'($urandom) | {7'h00, t == 9};
			cy(1);
			n = 7 + len + pe + ts;
			nb <= 4'(n);
			f = frm(d);
			wr(d);
			frame_wait();
			chk(remote_i.got.pop_front(), f, "tx frame");
			if (t == 5)
				f[6 + len] = ~f[6 + len];
			if (t == 9)
				f[6 + len + pe] = 1'b0;
			clr_seen();
			remote_i.send(f, n);
			cy(2);
			chk(rx_data, d & (8'hff >> (3 - len)), "rx data");
			chk({rx_avail, seen[3:2]}, {1'b1, t == 9, t == 5}, "rx err");
			pop();
		end
		$display("test framing done");
		{fe, fl, cts_n} <= 3'h3;
		cy(1);
		wr(8'h5a);
		cy(60);
		chk({tx_full, dts, txd}, 3'h5, "one byte held");
		cts_n <= 1'b0;
		frame_wait();
		chk(remote_i.got.pop_front(), frm(8'h5a), "paused");
		cy(20);
		chk(eot, 1, "end of tx");
		{fe, cts_n} <= 2'h3;
		$display("test flow done");
		for (int c = 0; c <= 16; c++) begin
			for (int k = 0; k < 5; k++) begin
				tl <= asp_lvl_t'(k);
				cy(2);
				chk({irq_tx, dtb}, {2{16 - c >= th(k)}}, "tx lvl");
			end
			chk(tx_full, c == 16, "tx full");
			wr(8'(c));
		end
		cy(2);
		chk({tx_full, dts, eot}, 3'h4, "tx refused");
		cts_n <= 1'b0;
		for (int i = 0; i < 5000 && !eot; i++)
			cy(1);
		cy(20);
		chk(remote_i.got.size(), 16, "frames sent");
		remote_i.got.delete();
		clr_seen();
		for (int c = 1; c <= 17; c++) begin
			// Flow off for the last frame so the port's receive FIFO may overrun
			if (c == 17)
				fl <= 1'b0;
			remote_i.send(frm(8'(c)), n);
			cy(2);
			for (int k = 0; k < 5; k++) begin
				rl <= asp_lvl_t'(k);
				cy(2);
				chk({irq_rx, drb}, {2{(c > 16 ? 16 : c) >= th(k)}}, "rx lvl");
			end
			chk({drs, rts_n}, {1'b1, c == 16}, "rx flags");
		end
		chk(seen[0], 1, "overrun");
		for (int c = 1; c <= 16; c++) begin
			chk(rx_data, 8'(c), "rx order");
			pop();
			cy(1);
		end
		chk({rx_avail, drs, rts_n}, 3'h0, "rx drained");
		$display("test fifo done");
		sb <= 1'b1;
		cy(40);
		chk(txd, 0, "break out");
		sb <= 1'b0;
		cy(300);
		remote_i.got.delete();
		clr_seen();
		remote_i.send(13'h0000, n);
		cy(2);
		chk({seen[1], rx_avail, txd}, 3'h5, "break in");
		$display("test break done");
		bd <= 16'h0002;
		cy(4);
		d = 8'($urandom);
		f = frm(d);
		wr(d);
		frame_wait();
		chk(remote_i.got.pop_front(), f, "tx div");
		remote_i.send(f, n);
		cy(4);
		chk({rx_avail, rx_data}, {1'b1, d & (8'hff >> (3 - len))}, "rx div");
		pop();
		$display("test divider done");
		results();
	end
endmodule
`default_nettype wire
